// *** include/asp_pkg.sv ***
// asp_pkg: constants and types shared by the serial port of the converter.
// assumes the port runs on one 40 MHz system clock.
`default_nettype none
package asp_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CFG_BITS = 8;
	localparam int START_BIT_POS = 7;
	localparam int RESULT_BITS = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int SYNC_STAGES = 3;
	localparam logic [15:0] SHIFT_RST = 16'h0000;
	localparam logic [3:0] CNT_RST = 4'h0;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_HUNT  = 2'b01,
		ST_SHIFT = 2'b10
	} asp_state_e;
endpackage
`default_nettype wire

// *** rtl/asp_fifo.sv ***
// asp_fifo: small synchronous FIFO held in flip-flops.
// assumes both sides run on clk; ready and valid follow the usual handshake.
`default_nettype none
module asp_fifo
	import asp_pkg::*;
#(
	parameter int WIDTH = RESULT_BITS,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// refused at elaboration: the pointers wrap by overflow only for powers of two
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("asp_fifo depth must be a power of two");

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} asp_fifo_s;

	asp_fifo_s st_reg;
	asp_fifo_s st_next;
	logic      push;
	logic      pop;

	assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.cnt != '0);
	assign out_data  = st_reg.mem[st_reg.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		st_next = st_reg;
		if (push)
		begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr = st_reg.wr + 1'b1;
		end
		if (pop)
			st_next.rd = st_reg.rd + 1'b1;
		if (push && !pop)
			st_next.cnt = st_reg.cnt + 1'b1;
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (rst)
		st_reg.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** rtl/asp_serial_port.sv ***
// asp_serial_port: pin-level serial host port of a multichannel converter.
// assumes the host is the bus master; all pins are asynchronous to clk and
// are sampled through three flip-flops. results arrive on a stream input.
//
// How it works
// R01: with select low, data input is sampled on each serial clock rise.
// R02: with select low, next output bit is shifted out on each clock fall.
// R03: with select high, clock and data are ignored and output is released.
// R04: in internal clock mode, a rising strobe marks a result ready to read.
// R05: in external clock mode the data-ready strobe is held low.
// R06: the data-ready strobe is always driven, whatever the select level.
// R07: first one sampled after select falls starts an eight-bit config byte.
// R08: select rising aborts a partial byte and clears the bit counter.
`default_nettype none
module asp_serial_port
	import asp_pkg::*;
#(
	parameter int DATA_W = RESULT_BITS,
	parameter int DEPTH  = FIFO_DEPTH
)
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              cs_n_pin,
	input  wire logic              sclk_pin,
	input  wire logic              din_pin,
	output logic                   dout_o,
	output logic                   dout_oe,
	output logic                   data_ready_strobe,
	input  wire logic              ext_clock_mode,
	input  wire logic              result_valid,
	output logic                   result_ready,
	input  wire logic [DATA_W-1:0] result_data,
	output logic                   cfg_valid,
	output logic [CFG_BITS-1:0]    cfg_byte
);
	// refused at elaboration: the output shifter is sixteen bits wide
	if (DATA_W < 1 || DATA_W > 16)
		$error("asp_serial_port data width must be 1 to 16");

	////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		logic [SYNC_STAGES-1:0] cs_sy;
		logic [SYNC_STAGES-1:0] ck_sy;
		logic [SYNC_STAGES-1:0] di_sy;
		logic                   cs_n;
		logic                   sck;
		logic                   din;
		asp_state_e             state;
		logic [3:0]             bit_cnt;
		logic [CFG_BITS-1:0]    cfg_sh;
		logic                   cfg_valid;
		logic [CFG_BITS-1:0]    cfg_byte;
		logic [15:0]            out_sh;
		logic                   dout;
		logic                   dout_oe;
		logic                   strobe;
		logic                   held;
	} asp_port_s;

	asp_port_s st_reg;
	asp_port_s st_next;

	logic              f_valid;
	logic              f_ready;
	logic [DATA_W-1:0] f_data;
	logic              sck_rise;
	logic              sck_fall;
	logic              cs_rise;
	logic              cs_fall;
	logic              sel;
	logic              load;

	// the strobe stands for "a word is waiting", so the fifo absorbs results
	// produced while the host is still reading an earlier one
	asp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo
	(
		.clk       (clk),
		.rst       (rst),
		.in_valid  (result_valid),
		.in_ready  (result_ready),
		.in_data   (result_data),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	////////////////////////////////////////////////////////////////////////
	// a level counts once the two later stages agree
	function automatic logic agreed(input logic [SYNC_STAGES-1:0] s, input logic old);
		agreed = (s[2] == s[1]) ? s[2] : old;
	endfunction

	always_comb
	begin
		st_next = st_reg;
		st_next.cs_sy = {st_reg.cs_sy[1:0], cs_n_pin};
		st_next.ck_sy = {st_reg.ck_sy[1:0], sclk_pin};
		st_next.di_sy = {st_reg.di_sy[1:0], din_pin};
		st_next.cs_n = agreed(st_reg.cs_sy, st_reg.cs_n);
		st_next.sck = agreed(st_reg.ck_sy, st_reg.sck);
		st_next.din = agreed(st_reg.di_sy, st_reg.din);
		st_next.cfg_valid = 1'b0;
		// edges in the cycle that select rises are dropped, so the abort is not undone
		sel = !st_reg.cs_n && !st_next.cs_n;
		sck_rise = sel && !st_reg.sck && st_next.sck;
		sck_fall = sel && st_reg.sck && !st_next.sck;
		cs_fall = st_reg.cs_n && !st_next.cs_n;
		cs_rise = !st_reg.cs_n && st_next.cs_n;
		load = 1'b0;

		if (cs_rise || st_reg.cs_n) // R03
		begin
			st_next.state = ST_IDLE; // R08
			st_next.bit_cnt = CNT_RST; // R08
			st_next.cfg_sh = '0;
			st_next.dout_oe = 1'b0; // R03
			st_next.dout = 1'b0;
		end
		if (cs_fall)
		begin
			st_next.state = ST_HUNT;
			st_next.dout_oe = 1'b1;
			st_next.dout = st_reg.out_sh[15];
			st_next.held = 1'b0;
		end
		else if (sck_rise) // R01
		begin
			case (st_reg.state)
				ST_HUNT:
				begin
					if (st_next.din) // R07
					begin
						st_next.state = ST_SHIFT;
						st_next.cfg_sh = {{(CFG_BITS-1){1'b0}}, 1'b1};
						st_next.bit_cnt = 4'h1;
					end
				end
				ST_SHIFT:
				begin
					st_next.cfg_sh = {st_reg.cfg_sh[CFG_BITS-2:0], st_next.din};
					if (st_reg.bit_cnt == 4'(CFG_BITS - 1))
					begin
						st_next.cfg_valid = 1'b1;
						st_next.cfg_byte = {st_reg.cfg_sh[CFG_BITS-2:0], st_next.din};
						st_next.state = ST_HUNT;
						st_next.bit_cnt = CNT_RST;
					end
					else
						st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
				end
				default: ;
			endcase
		end
		else if (sck_fall) // R02
		begin
			st_next.dout = st_reg.out_sh[14];
			st_next.out_sh = {st_reg.out_sh[14:0], 1'b0};
		end

		// a waiting word is taken into the shifter only while the port is idle and
		// no unread word sits there; in external mode this keeps later results
		// from overwriting one the host has not yet selected
		if (st_reg.cs_n && !cs_fall && f_valid && !st_reg.held)
		begin
			load = 1'b1;
			st_next.held = 1'b1;
			st_next.out_sh = 16'(f_data) << (16 - DATA_W);
		end
		// in internal mode, strobe rises with a loaded word and falls once the host selects
		if (ext_clock_mode)
			st_next.strobe = 1'b0; // R05
		else if (load)
			st_next.strobe = 1'b1; // R04
		else if (cs_fall)
			st_next.strobe = 1'b0;
	end

	assign f_ready = load;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.cs_sy <= 3'h7;
			st_reg.cs_n <= 1'b1;
			st_reg.out_sh <= SHIFT_RST;
		end
		else
			st_reg <= st_next;
	end

	assign dout_o = st_reg.dout;
	assign dout_oe = st_reg.dout_oe;
	assign data_ready_strobe = st_reg.strobe; // R06
	assign cfg_valid = st_reg.cfg_valid;
	assign cfg_byte = st_reg.cfg_byte;

	////////////////////////////////////////////////////////////////////////
	a_hiz_when_idle: assert property (@(posedge clk) disable iff (rst) // R03
		st_reg.cs_n && $past(st_reg.cs_n) |-> !dout_oe) else $error("dout driven while idle");
	a_ext_strobe_low: assert property (@(posedge clk) disable iff (rst) // R05
		$past(ext_clock_mode) |-> !data_ready_strobe) else $error("strobe high in ext mode");
	a_strobe_rise: assert property (@(posedge clk) disable iff (rst) // R04
		$rose(data_ready_strobe) |-> $past(f_valid) && $past(st_reg.cs_n))
		else $error("strobe rose with no word");
	a_abort_clear: assert property (@(posedge clk) disable iff (rst) // R08
		cs_rise |=> st_reg.bit_cnt == CNT_RST && st_reg.state == ST_IDLE)
		else $error("abort did not clear");
	a_start_bit: assert property (@(posedge clk) disable iff (rst) // R07
		st_reg.state == ST_HUNT && sck_rise && st_next.din |=> st_reg.state == ST_SHIFT)
		else $error("start bit missed");
	a_shift_on_fall: assert property (@(posedge clk) disable iff (rst) // R02
		sck_fall && !cs_fall |=> dout_o == $past(st_reg.out_sh[14]))
		else $error("dout not shifted");
	a_byte_done: assert property (@(posedge clk) disable iff (rst) // R07
		cfg_valid |-> $past(st_reg.state) == ST_SHIFT && $past(st_reg.bit_cnt) == 4'h7)
		else $error("byte ended early");
	a_enable_on_sel: assert property (@(posedge clk) disable iff (rst) // R02
		cs_fall |=> dout_oe) else $error("dout not enabled");

	c_byte_received: cover property (@(posedge clk) disable iff (rst) cfg_valid);
	c_strobe_rise: cover property (@(posedge clk) disable iff (rst) $rose(data_ready_strobe));
	c_abort: cover property (@(posedge clk) disable iff (rst)
		cs_rise && st_reg.state == ST_SHIFT);
endmodule
`default_nettype wire

// *** test/asp_host_model.sv ***
// asp_host_model: behavioural serial bus master facing the converter port.
// assumes pins launch on clk rises; one serial clock phase is four clk.
`default_nettype none
module asp_host_model
(
	input  wire logic clk,
	output var logic  cs_n_pin,
	output var logic  sclk_pin,
	output var logic  din_pin,
	input  wire logic dout_o,
	input  wire logic dout_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_reg = 1'b0;
	logic dout_line;
	// no pull on the line: a released pin shows the inverse of its last level
	assign dout_line = dout_oe ? dout_o : ~last_reg;
	always @(posedge clk)
		if (dout_oe)
			last_reg <= dout_o;
	initial
	begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		din_pin  = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
		cs_n_pin <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 23; i >= 0; i--)
		begin
			din_pin <= tx[i];
			repeat (4) @(posedge clk);
			sclk_pin <= 1'b1;
			repeat (3) @(posedge clk);
			// read mid-cycle late in the high phase, well clear of the output update
			@(negedge clk) rx[i] = dout_line;
			@(posedge clk);
			sclk_pin <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n_pin <= 1'b1;
		repeat (12) @(posedge clk);
	endtask
	task automatic noise();
		din_pin <= 1'b1;
		repeat (8)
		begin
			repeat (4) @(posedge clk);
			sclk_pin <= ~sclk_pin;
		end
		din_pin <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// tb_top: self-checking bench for the converter serial port.
// assumes the host model drives the pins and the bench feeds results.
`default_nettype none
module tb_top
	import asp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk;
	logic              rst;
	logic              cs_n_pin;
	logic              sclk_pin;
	logic              din_pin;
	logic              dout_o;
	logic              dout_oe;
	logic              data_ready_strobe;
	logic              ext_clock_mode;
	logic              result_valid;
	logic              result_ready;
	logic [15:0]       result_data;
	logic              cfg_valid;
	logic [7:0]        cfg_byte;
	logic [23:0]       rx;
	int                num_errors = 0;
	int                checks_done = 0;
	int                cycles = 0;
	int                cfg_seen = 0;
	asp_serial_port #(.DATA_W(RESULT_BITS), .DEPTH(FIFO_DEPTH)) DUT (.clk(clk), .rst(rst),
		.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin), .dout_o(dout_o),
		.dout_oe(dout_oe), .data_ready_strobe(data_ready_strobe),
		.ext_clock_mode(ext_clock_mode), .result_valid(result_valid),
		.result_ready(result_ready), .result_data(result_data),
		.cfg_valid(cfg_valid), .cfg_byte(cfg_byte));
	asp_host_model host (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
		.din_pin(din_pin), .dout_o(dout_o), .dout_oe(dout_oe));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cfg_valid === 1'b1)
			cfg_seen++;
		if (cycles == 20000)
		begin
			num_errors++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
			num_errors++;
		end
	endtask
	task automatic wait_strobe(input logic e);
		int n;
		n = 0;
		while (data_ready_strobe !== e && n < 60)
		begin
			@(posedge clk);
			n++;
		end
		chk("strobe", {23'h0, e}, {23'h0, data_ready_strobe});
	endtask
	task automatic summarize();
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_fill_drain();
		int n;
		logic ok;
		n = 0;
		ok = 1'b1;
		result_valid <= 1'b1;
		result_data <= 16'ha000;
		while (ok && n < 40)
		begin
			@(negedge clk) ok = result_ready;
			@(posedge clk);
			if (ok)
			begin
				n++;
				result_data <= 16'ha000 + n[15:0];
			end
		end
		result_valid <= 1'b0;
		chk("accepted", 24'(FIFO_DEPTH + 1), 24'(n));
		wait_strobe(1'b1);
		cfg_seen = 0;
		for (int k = 0; k < n; k++)
		begin
			host.frame({8'h00, 8'h80 | k[7:0], 8'h00}, rx);
			chk("word", 24'(16'ha000 + k[15:0]), 24'(rx[23:8]));
			chk("cfg byte", 24'(8'h80 | k[7:0]), 24'(cfg_byte));
			chk("out enable", 24'h0, 24'(dout_oe));
			if (k < n - 1)
				wait_strobe(1'b1);
		end
		chk("cfg pulses", 24'(n), 24'(cfg_seen));
	endtask
	task automatic t_noise_abort();
		cfg_seen = 0;
		host.noise();
		repeat (8) @(posedge clk);
		chk("noise cfg", 24'h0, 24'(cfg_seen));
		chk("noise enable", 24'h0, 24'(dout_oe));
		// partial byte 1011 left hanging when select rises
		host.frame(24'h00000b, rx);
		host.frame(24'h009600, rx);
		chk("abort cfg", 24'h96, 24'(cfg_byte));
		chk("abort pulses", 24'h1, 24'(cfg_seen));
	endtask
	task automatic t_ext();
		ext_clock_mode <= 1'b1;
		result_valid <= 1'b1;
		result_data <= 16'h5a3c;
		@(posedge clk);
		result_data <= 16'h3c5a;
		@(posedge clk);
		result_valid <= 1'b0;
		repeat (40)
		begin
			@(posedge clk);
			chk("ext strobe", 24'h0, 24'(data_ready_strobe));
		end
		host.frame(24'h000000, rx);
		chk("ext word", 24'h5a3c, 24'(rx[23:8]));
		chk("ext strobe framed", 24'h0, 24'(data_ready_strobe));
		host.frame(24'h000000, rx);
		chk("ext second word", 24'h3c5a, 24'(rx[23:8]));
		ext_clock_mode <= 1'b0;
	endtask
	initial
	begin
		rst = 1'b1;
		ext_clock_mode = 1'b0;
		result_valid = 1'b0;
		result_data = 16'h0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reset enable", 24'h0, 24'(dout_oe));
		chk("reset strobe", 24'h0, 24'(data_ready_strobe));
		chk("reset ready", 24'h1, 24'(result_ready));
		t_fill_drain();
		t_noise_abort();
		t_ext();
		summarize();
	end
endmodule
`default_nettype wire
